/* logic/paset_regs.sv */
// Partner ability, expansion status and power-down timing registers with the
// link pulse timer, the wake detector and the crossover extension timer.
// Assumes a decoded management access port and one-cycle event pulses from
// the auto-negotiation and receive logic, all synchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module paset_regs #(
  parameter logic [31:0] CYC_1000 = paset_pkg::CYC_1000,
  parameter logic [31:0] CYC_768 = paset_pkg::CYC_768,
  parameter logic [31:0] CYC_512 = paset_pkg::CYC_512,
  parameter logic [31:0] CYC_256 = paset_pkg::CYC_256,
  parameter logic [31:0] CYC_64 = paset_pkg::CYC_64,
  parameter logic [31:0] CYC_XPD = paset_pkg::CYC_XPD,
  parameter logic [31:0] CYC_XMAN = paset_pkg::CYC_XMAN
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Management register access.
  input wire logic mgmt_rd_i,
  input wire logic mgmt_wr_i,
  input wire logic [4:0] mgmt_idx_i,
  input wire logic [15:0] mgmt_wdata_i,
  output logic [15:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  // Auto-negotiation events.
  input wire logic lcw_valid_i,
  input wire logic [15:0] lcw_i,
  input wire logic pd_fault_i,
  input wire logic partner_an_able_i,
  // Power-down and crossover context.
  input wire logic power_down_enable_bit_i,
  input wire logic automatic_crossover_i,
  input wire logic manual_speed_i,
  input wire logic rx_nlp_i,
  input wire logic xover_start_i,
  // Power-down outputs.
  output logic nlp_tx_o,
  output logic wake_o,
  output logic xover_busy_o
);

  logic [15:0] lp_ff;
  logic pdf_ff;
  logic page_ff;
  logic lpan_ff;
  logic [15:0] tm_ff;
  logic [31:0] txcnt_ff;
  logic [31:0] gap_ff;
  logic armed_ff;
  logic [31:0] xcnt_ff;
  logic rd_ex;
  logic tx_act;
  logic rx_act;
  logic [31:0] tx_per;
  logic [31:0] rx_max;
  logic [31:0] xext;

  // Assertions below share this clock and stay quiet while reset is held.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Maps a two-bit select onto one of four interval counts.
  function automatic logic [31:0] pick4(input logic [1:0] sel, input logic [31:0] a,
                                        input logic [31:0] b, input logic [31:0] c,
                                        input logic [31:0] d);
    unique case (sel)
      2'h0: pick4 = a;
      2'h1: pick4 = b;
      2'h2: pick4 = c;
      default: pick4 = d;
    endcase
  endfunction

  // Decoded controls; every timing field except the manual crossover bit is dead unless power-down is on.
  assign rd_ex = mgmt_rd_i && (mgmt_idx_i == paset_pkg::AUTONEG_EXPANSION_STATUS_IDX);
  assign tx_act = power_down_enable_bit_i && tm_ff[paset_pkg::TM_TXEN_BIT];
  assign rx_act = power_down_enable_bit_i;
  assign tx_per = pick4(tm_ff[paset_pkg::TM_TXSEL_LSB +: 2], CYC_1000, CYC_768,
                        CYC_512, CYC_256);
  assign rx_max = pick4(tm_ff[paset_pkg::TM_RXSEL_LSB +: 2], CYC_64, CYC_256,
                        CYC_512, CYC_1000);
  assign xext = ((power_down_enable_bit_i && tm_ff[paset_pkg::TM_XPD_BIT]) ? CYC_XPD
                 : 32'h0) +
                ((automatic_crossover_i && manual_speed_i && tm_ff[paset_pkg::TM_XMAN_BIT])
                 ? CYC_XMAN : 32'h0);

  // Partner ability loads the capture-mask fields from the base code word; selector and acknowledge forced on.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lp_ff <= paset_pkg::LP_RESET;
    end else if (lcw_valid_i) begin
      lp_ff <= (lcw_i & paset_pkg::LP_CAPTURE_MASK) | paset_pkg::LP_RESET;
      lp_ff[paset_pkg::LP_ACK_BIT] <= 1'b1;
    end
  end

  // The acknowledge only rises on a code word and never drops outside reset.
  ack_rise_a: assert property ($rose(lp_ff[paset_pkg::LP_ACK_BIT]) |->
    $past(lcw_valid_i))
    else $error("acknowledge rose without a code word");
  ack_keep_a: assert property (!$fell(lp_ff[paset_pkg::LP_ACK_BIT]))
    else $error("acknowledge bit dropped");
  // Between code words every partner field must hold still.
  lp_hold_a: assert property (!lcw_valid_i |=> $stable(lp_ff))
    else $error("partner ability changed without a code word");
  lp_rsvd_a: assert property (lp_ff[12] == 1'b0)
    else $error("reserved partner bit set");

  // Latched-high bits: an event in the read cycle wins over the clear.
  // Letting the set win means an event is never lost to a read that did not show it.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pdf_ff <= 1'b0;
      page_ff <= 1'b0;
    end else begin
      pdf_ff <= pd_fault_i || (pdf_ff && !rd_ex);
      page_ff <= lcw_valid_i || (page_ff && !rd_ex);
    end
  end

  // A set flag survives every cycle without a read of the expansion register.
  pdf_hold_a: assert property (pdf_ff && !rd_ex |=> pdf_ff)
    else $error("fault flag lost without a read");
  pdf_clear_a: assert property (pdf_ff && rd_ex && !pd_fault_i |=> !pdf_ff)
    else $error("fault flag not cleared on read");
  page_hold_a: assert property (page_ff && !rd_ex |=> page_ff)
    else $error("page flag lost without a read");

  // Partner auto-negotiation ability is a live level, registered once.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lpan_ff <= 1'b0;
    end else begin
      lpan_ff <= partner_an_able_i;
    end
  end

  // The ability bit follows its input one cycle late.
  lpan_follow_a: assert property (1'b1 |=> lpan_ff == $past(partner_an_able_i))
    else $error("partner auto-negotiation bit stale");

  // Timing register; reserved bits are masked so they always read zero.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tm_ff <= paset_pkg::TM_RESET;
    end else if (mgmt_wr_i && mgmt_idx_i == paset_pkg::PD_TIMING_IDX) begin
      tm_ff <= mgmt_wdata_i & paset_pkg::TM_WRITE_MASK;
    end
  end

  // A timing write lands whole, with the reserved bits forced to zero.
  tm_write_a: assert property (mgmt_wr_i && mgmt_idx_i == paset_pkg::PD_TIMING_IDX |=>
    tm_ff == ($past(mgmt_wdata_i) & paset_pkg::TM_WRITE_MASK))
    else $error("timing register write not taken");

  // Read port; writes to the read-only registers are ignored.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mgmt_rdata_o <= 16'h0000;
      mgmt_rvalid_o <= 1'b0;
    end else begin
      mgmt_rvalid_o <= mgmt_rd_i;
      if (mgmt_rd_i) begin
        unique case (mgmt_idx_i)
          paset_pkg::LP_ABILITY_IDX: mgmt_rdata_o <= lp_ff;
          paset_pkg::AUTONEG_EXPANSION_STATUS_IDX: mgmt_rdata_o <= {11'h000, pdf_ff,
                                                      lp_ff[paset_pkg::LP_NP_BIT], 1'b0,
                                                      page_ff, lpan_ff};
          paset_pkg::PD_TIMING_IDX: mgmt_rdata_o <= tm_ff;
          default: mgmt_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // Each read is answered one cycle later and the data holds until the next read.
  rvalid_a: assert property (1'b1 |=> mgmt_rvalid_o == $past(mgmt_rd_i))
    else $error("read answer not one cycle after request");
  rdata_keep_a: assert property (!mgmt_rd_i |=> $stable(mgmt_rdata_o))
    else $error("read data changed without a read");
  exp_flags_a: assert property (rd_ex |=>
    mgmt_rdata_o[paset_pkg::EX_PDF_BIT] == $past(pdf_ff) &&
    mgmt_rdata_o[paset_pkg::EX_PAGE_BIT] == $past(page_ff) &&
    mgmt_rdata_o[paset_pkg::EX_LPAN_BIT] == $past(lpan_ff))
    else $error("expansion flags wrong in read");
  exp_rsvd_a: assert property (rd_ex |=> mgmt_rdata_o[15:5] == 11'h000)
    else $error("reserved expansion bits set");
  lp_read_a: assert property (mgmt_rd_i && mgmt_idx_i == paset_pkg::LP_ABILITY_IDX |=>
    mgmt_rdata_o == $past(lp_ff))
    else $error("partner ability read wrong");

  // Link pulse transmit timer; it restarts whenever transmit is disabled.
  // The compare uses >= so a shorter interval written mid-count fires at once.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      txcnt_ff <= 32'h0;
      nlp_tx_o <= 1'b0;
    end else if (!tx_act) begin
      txcnt_ff <= 32'h0;
      nlp_tx_o <= 1'b0;
    end else if (txcnt_ff >= tx_per - 32'h1) begin
      txcnt_ff <= 32'h0;
      nlp_tx_o <= 1'b1;
    end else begin
      txcnt_ff <= txcnt_ff + 32'h1;
      nlp_tx_o <= 1'b0;
    end
  end

  // A link pulse lasts one cycle and is only sent while enabled.
  ntx_gate_a: assert property (nlp_tx_o |-> $past(tx_act))
    else $error("link pulse sent while not enabled");
  ntx_single_a: assert property (nlp_tx_o |=> !nlp_tx_o)
    else $error("link pulse longer than one cycle");

  // Wake detector: one pulse, or two pulses no farther apart than the limit.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      armed_ff <= 1'b0;
      gap_ff <= 32'h0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      if (!rx_act) begin
        armed_ff <= 1'b0;
        gap_ff <= 32'h0;
      end else if (rx_nlp_i && tm_ff[paset_pkg::TM_RXONE_BIT]) begin
        wake_o <= 1'b1;
        armed_ff <= 1'b0;
      end else if (rx_nlp_i && armed_ff) begin
        wake_o <= 1'b1;
        armed_ff <= 1'b0;
      end else if (rx_nlp_i) begin
        armed_ff <= 1'b1;
        gap_ff <= 32'h0;
      end else if (armed_ff) begin
        // The first pulse expires once the gap limit passes.
        armed_ff <= (gap_ff < rx_max - 32'h1);
        gap_ff <= gap_ff + 32'h1;
      end
    end
  end

  // Wake needs a received pulse in power-down; without the single-pulse bit a lone first pulse only arms.
  wake_cause_a: assert property (wake_o |-> $past(rx_nlp_i) && $past(rx_act))
    else $error("wake without a received pulse");
  wake_off_a: assert property (!rx_act |=> !wake_o)
    else $error("wake outside power-down");
  wake_arm_a: assert property (rx_act && !tm_ff[paset_pkg::TM_RXONE_BIT] && rx_nlp_i &&
    !armed_ff |=> !wake_o && armed_ff)
    else $error("first pulse did not arm the detector");

  // Crossover extension: busy for the summed extension after each start.
  // Only the extra time is modelled; the base crossover timing lives elsewhere.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      xcnt_ff <= 32'h0;
      xover_busy_o <= 1'b0;
    end else if (xover_start_i) begin
      xcnt_ff <= xext;
      xover_busy_o <= (xext != 32'h0);
    end else if (xcnt_ff > 32'h1) begin
      xcnt_ff <= xcnt_ff - 32'h1;
    end else begin
      xcnt_ff <= 32'h0;
      xover_busy_o <= 1'b0;
    end
  end

  // The manual extension alone opens a window; no extension opens none.
  xover_man_a: assert property (xover_start_i && automatic_crossover_i &&
    manual_speed_i && tm_ff[paset_pkg::TM_XMAN_BIT] |=> xover_busy_o && xcnt_ff >= CYC_XMAN)
    else $error("manual crossover extension missing");
  xover_none_a: assert property (xover_start_i && xext == 32'h0 |=> !xover_busy_o)
    else $error("busy without any extension");
  xover_end_a: assert property (xover_busy_o && xcnt_ff == 32'h1 && !xover_start_i |=>
    !xover_busy_o)
    else $error("crossover window overran");

  ack_set_a: assert property (lcw_valid_i |=> lp_ff[paset_pkg::LP_ACK_BIT])
    else $error("acknowledge bit not set after code word");
  fields_load_a: assert property (lcw_valid_i |=> lp_ff[15] == $past(lcw_i[15]) &&
    lp_ff[13] == $past(lcw_i[13]) && lp_ff[11:5] == $past(lcw_i[11:5]))
    else $error("partner fields not loaded from code word");
  selector_ro_a: assert property (lp_ff[4:0] == 5'h01)
    else $error("selector field changed");
  pdf_latch_a: assert property (pd_fault_i |=> pdf_ff)
    else $error("parallel fault not latched");
  page_clear_a: assert property (page_ff && rd_ex && !lcw_valid_i |=> !page_ff)
    else $error("page bit not cleared on read");
  page_set_a: assert property (lcw_valid_i && rd_ex |=> page_ff)
    else $error("page event lost against clear");
  exp_np_a: assert property (rd_ex |=> mgmt_rdata_o[paset_pkg::EX_NP_BIT] == 1'b0 &&
    mgmt_rdata_o[paset_pkg::EX_LPNP_BIT] == $past(lp_ff[15]))
    else $error("next page bits wrong in expansion read");
  ntx_off_a: assert property (!tx_act |=> !nlp_tx_o [*2])
    else $error("link pulse sent while disabled");
  wake_one_a: assert property (rx_act && tm_ff[12] && rx_nlp_i |=> wake_o)
    else $error("single pulse wake missed");
  xover_pd_a: assert property (xover_start_i && power_down_enable_bit_i && tm_ff[1]
    |=> xover_busy_o && xcnt_ff >= CYC_XPD)
    else $error("power-down crossover extension missing");
endmodule
`default_nettype wire

/* logic/paset_pkg.sv */
// Constants for the partner ability, expansion and power-down timing registers.
// Assumes a 200 MHz management clock and a decoded register access port.
package paset_pkg;
  // Register indices on the management port.
  localparam logic [4:0] LP_ABILITY_IDX = 5'h05;
  localparam logic [4:0] AUTONEG_EXPANSION_STATUS_IDX = 5'h06;
  localparam logic [4:0] PD_TIMING_IDX = 5'h10;
  // Partner ability field positions.
  localparam int LP_NP_BIT = 15;
  localparam int LP_ACK_BIT = 14;
  localparam int LP_RF_BIT = 13;
  localparam int LP_T4_BIT = 9;
  localparam logic [15:0] LP_RESET = 16'h0001;
  localparam logic [15:0] LP_CAPTURE_MASK = 16'hafe0;
  // Expansion register bit positions.
  localparam int EX_PDF_BIT = 4;
  localparam int EX_LPNP_BIT = 3;
  localparam int EX_NP_BIT = 2;
  localparam int EX_PAGE_BIT = 1;
  localparam int EX_LPAN_BIT = 0;
  // Timing register layout.
  localparam int TM_TXEN_BIT = 15;
  localparam int TM_TXSEL_LSB = 13;
  localparam int TM_RXONE_BIT = 12;
  localparam int TM_RXSEL_LSB = 10;
  localparam int TM_XPD_BIT = 1;
  localparam int TM_XMAN_BIT = 0;
  localparam logic [15:0] TM_RESET = 16'h0000;
  localparam logic [15:0] TM_WRITE_MASK = 16'hfc03;
  // Times in milliseconds and their cycle counts at 200 MHz.
  localparam longint CYC_PER_MS = 64'd200000;
  localparam longint T_1000_MS = 64'd1000;
  localparam longint T_768_MS = 64'd768;
  localparam longint T_512_MS = 64'd512;
  localparam longint T_256_MS = 64'd256;
  localparam longint T_64_MS = 64'd64;
  localparam longint T_XPD_MS = 64'd2976;
  localparam longint T_XMAN_MS = 64'd1984;
  localparam logic [31:0] CYC_1000 = 32'(T_1000_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_768 = 32'(T_768_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_512 = 32'(T_512_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_256 = 32'(T_256_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_64 = 32'(T_64_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_XPD = 32'(T_XPD_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_XMAN = 32'(T_XMAN_MS * CYC_PER_MS);
endpackage

/* bench/paset_partner.sv */
// Link partner model: base code words and single received link pulses.
// Assumes the bench drives its requests just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module paset_partner (
  // Requests from the bench.
  input wire logic send_i,
  input wire logic [15:0] word_i,
  input wire logic pulse_i,
  // Towards the block.
  output logic lcw_valid_o,
  output logic [15:0] lcw_o,
  output logic rx_nlp_o
);
  logic [15:0] last_word = 16'h0000;
  // Between words the data shows the inverse of the last one, so a stale capture fails.
  always_comb begin
    lcw_valid_o = send_i;
    lcw_o = send_i ? word_i : ~last_word;
    rx_nlp_o = pulse_i;
  end
  // The word is remembered as it is sent.
  always @(posedge send_i) last_word = word_i;
endmodule
`default_nettype wire

/* bench/paset_regs_bench.sv */
// Self-checking bench for the partner ability, expansion and timing registers.
// Assumes the short timing parameters set below; all expectations follow them.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module paset_regs_bench;
  logic clk_sys_i = 0, rst_i = 1, mrd = 0, mwr = 0, rvalid, send = 0, pulse = 0;
  logic lv, rnlp, pdf = 0, an = 0, pden = 0, ax = 0, man = 0, xs = 0;
  logic nlp, wake, busy, woke = 0, tx_seen = 0;
  logic [4:0] idx = 5'h00;
  logic [15:0] wd = 16'h0000, rdata, w = 16'h0016, word = 16'h0000, e, lw;
  logic [15:0] q[$];
  logic [4:0] xc[4] = '{5'b10010, 5'b01101, 5'b11111, 5'b01011};
  localparam int P_1000 = 40, P_768 = 32, P_512 = 24, P_256 = 16, P_64 = 8;
  localparam int P_XPD = 60, P_XMAN = 50;
  int ivl[4] = '{P_1000, P_768, P_512, P_256};
  int gap[4] = '{P_64, P_256, P_512, P_1000};
  int xe[4] = '{P_XPD, P_XMAN, P_XPD + P_XMAN, 0};
  int n_fail = 0, total_checks = 0, n;
  paset_regs #(.CYC_1000(P_1000), .CYC_768(P_768), .CYC_512(P_512), .CYC_256(P_256),
    .CYC_64(P_64), .CYC_XPD(P_XPD), .CYC_XMAN(P_XMAN)) u_dut (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .mgmt_rd_i(mrd), .mgmt_wr_i(mwr), .mgmt_idx_i(idx), .mgmt_wdata_i(wd),
    .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid), .lcw_valid_i(lv), .lcw_i(lw),
    .pd_fault_i(pdf), .partner_an_able_i(an), .power_down_enable_bit_i(pden),
    .automatic_crossover_i(ax), .manual_speed_i(man), .rx_nlp_i(rnlp),
    .xover_start_i(xs), .nlp_tx_o(nlp), .wake_o(wake), .xover_busy_o(busy));
  paset_partner u_partner (.send_i(send), .word_i(word), .pulse_i(pulse),
    .lcw_valid_o(lv), .lcw_o(lw), .rx_nlp_o(rnlp));
  // Clock at 200 MHz.
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Each answered read takes the oldest noted value off the queue.
  always @(negedge clk_sys_i) if (rvalid === 1'b1) begin
    e = (q.size() > 0) ? q.pop_front() : 16'hxxxx;
    `CHK(rdata, e, "read data")
  end
  // Sticky flags, because the pulses last one cycle only.
  always @(posedge clk_sys_i) if (wake === 1'b1) woke <= 1'b1;
  always @(posedge clk_sys_i) if (nlp === 1'b1) tx_seen <= 1'b1;
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] x);
    q.push_back(x);
    idx = a;
    mrd = 1;
    @(negedge clk_sys_i) mrd = 0;
    @(negedge clk_sys_i);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    idx = a;
    wd = d;
    mwr = 1;
    @(negedge clk_sys_i) mwr = 0;
    @(negedge clk_sys_i);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  task automatic nlp_pulse();
    pulse = 1;
    @(negedge clk_sys_i) pulse = 0;
  endtask
  // Waits for a sent pulse, then counts cycles to the next one.
  task automatic per(output int k);
    int i;
    i = 0;
    while (nlp !== 1'b1 && i < 200) begin
      @(negedge clk_sys_i);
      i++;
    end
    k = 0;
    do begin
      @(negedge clk_sys_i);
      k++;
    end while (nlp !== 1'b1 && k < 200);
    if (i >= 200 || k >= 200) begin
      n_fail++;
      end_sim();
    end
  endtask
  // Watchdog: a hang counts as a failure.
  initial begin
    cyc(20000);
    n_fail++;
    end_sim();
  end
  initial begin
    cyc(6);
    rst_i = 0;
    rd_reg(5'h05, 16'h0001);
    rd_reg(5'h06, 16'h0000);
    rd_reg(5'h10, 16'h0000);
    wr_reg(5'h10, 16'hffff);
    wr_reg(5'h05, 16'h1234);
    rd_reg(5'h10, 16'hfc03);
    rd_reg(5'h05, 16'h0001);
    rd_reg(5'h07, 16'h0000);
    $display("register access done");
    // Random words; the pause field walks through all four codes.
    for (int i = 0; i < 8; i++) begin
      w = lfsr(w);
      w[11:10] = 2'(i);
      an = w[0];
      word = w;
      send = 1;
      @(negedge clk_sys_i) send = 0;
      rd_reg(5'h05, (w & 16'hafe0) | 16'h4001);
      rd_reg(5'h06, {12'h000, w[15], 1'b0, 1'b1, an});
      rd_reg(5'h06, {12'h000, w[15], 2'b00, an});
    end
    // Fault and code word in the read cycle: the read shows old flags, the set wins.
    q.push_back({12'h000, w[15], 2'b00, an});
    idx = 5'h06;
    mrd = 1;
    pdf = 1;
    send = 1;
    @(negedge clk_sys_i) begin
      mrd = 0;
      pdf = 0;
      send = 0;
    end
    @(negedge clk_sys_i);
    rd_reg(5'h06, {11'h000, 1'b1, w[15], 1'b0, 1'b1, an});
    rd_reg(5'h06, {12'h000, w[15], 2'b00, an});
    $display("code word and status done");
    pden = 1;
    for (int s = 0; s < 4; s++) begin
      wr_reg(5'h10, 16'h8000 | 16'(s << 13));
      per(n);
      per(n);
      `CHK(n, ivl[s], "pulse period")
    end
    pden = 0;
    wr_reg(5'h10, 16'h8000);
    cyc(3);
    tx_seen = 0;
    cyc(60);
    `CHK(tx_seen, 1'b0, "pulses without power-down")
    pden = 1;
    wr_reg(5'h10, 16'h1000);
    cyc(3);
    tx_seen = 0;
    cyc(60);
    `CHK(tx_seen, 1'b0, "pulses disabled")
    $display("link pulse timing done");
    woke = 0;
    nlp_pulse();
    cyc(3);
    `CHK(woke, 1'b1, "single pulse wake")
    pden = 0;
    woke = 0;
    nlp_pulse();
    cyc(3);
    `CHK(woke, 1'b0, "wake without power-down")
    pden = 1;
    for (int s = 0; s < 4; s++) begin
      wr_reg(5'h10, 16'(s << 10));
      cyc(gap[s] * 3);
      woke = 0;
      nlp_pulse();
      cyc(gap[s] * 2 + 2);
      nlp_pulse();
      cyc(3);
      `CHK(woke, 1'b0, "slow pulse pair")
      nlp_pulse();
      cyc(3);
      `CHK(woke, 1'b1, "fast pulse pair")
    end
    $display("wake done");
    foreach (xe[c]) begin
      {pden, ax, man} = xc[c][4:2];
      wr_reg(5'h10, {14'h0000, xc[c][1:0]});
      xs = 1;
      @(negedge clk_sys_i) xs = 0;
      n = 0;
      while (busy === 1'b1 && n < 400) begin
        @(negedge clk_sys_i);
        n++;
      end
      if (n >= 400) begin
        n_fail++;
        end_sim();
      end
      `CHK(n, xe[c], "crossover extension")
    end
    $display("crossover done");
    cyc(5);
    `CHK(q.size(), 0, "reads answered")
    end_sim();
  end
endmodule
`default_nettype wire
